// File: hdl/wse_seq.sv
/*
 * Wake-event sequencer top: AHB-Lite registers holding the idle frame,
 * power-up, hibernate and sleep states, timeout timer and tag detect loop.
 * Assumes slow oscillator, carrier swings, wake pins and DAC level arrive
 * asynchronously on pins; the bus is a single AHB-Lite master.
 */
// Function
// - power-up waits for wake-request low pulse, then ready about 6 ms later
// - hibernate ignores every wake source except the wake-request pulse
// - wake byte bits: 0x01 timeout, 0x02 tag, 0x08 request pin, 0x10 select pin
// - several sources may be enabled together; any one ends the wait
// - slow oscillator runs during sleep whenever timeout or tag wake is selected
// - timeout is 256 slow periods times (coeff+2) times (limit+1)
// - timeout bit limits bursts; otherwise bursts repeat until a stop event
// - RF bursts only when tag detect bit is set
// - gap between bursts is (coeff+2) base intervals, coeff at byte 10
// - base interval is 256 slow periods, rate chosen by bits 7:6
// - before burst wait fast osc settle then DAC settle, bytes 11, 12
// - burst lasts byte 15 carrier swings
// - with timeout, limit+1 bursts then timeout wake; limit at byte 16
// - each burst samples drive current into the 6-bit DAC value
// - tag wake when value above high or below low threshold
// - idle frame decoded by fixed byte position, wake byte at 3
`timescale 1ns/100ps
module wse_seq
  import wse_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_wake_req_n,
  input wire logic i_ser_sel_n,
  input wire logic i_slow_osc,
  input wire logic i_rf_swing,
  input wire logic [5:0] i_dac_level,
  output logic o_slow_osc_en,
  output logic [1:0] o_slow_osc_sel,
  output logic o_fast_osc_en,
  output logic o_dac_en,
  output logic o_rf_burst_en,
  output logic o_ready,
  output logic o_hibernate
);

  typedef struct packed {
    wse_state_e st;
    logic [3:0][31:0] frame;
    logic [7:0] reason;
    logic [5:0] dac_raw;
    logic [7:0] meas;
    logic [LIMIT_W:0] bursts;
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic slow_en;
    logic [1:0] slow_sel;
    logic fast_en;
    logic dac_en;
    logic rf_en;
    logic ready;
    logic hiber;
  } wse_seq_s;

  wse_seq_s r_reg;
  wse_seq_s r_next;

  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [5:0] dac_sync;
  logic a_load;
  logic [CNT_A_W-1:0] a_value;
  logic [CNT_A_W-1:0] a_count;
  logic a_done;
  logic b_load;
  logic [CNT_B_W-1:0] b_value;
  logic [CNT_B_W-1:0] b_count;
  logic b_done;
  logic req_fall;
  logic sel_fall;
  logic slow_tick;
  logic swing_tick;
  logic [7:0] wsrc;
  logic [7:0] pin_reason;
  logic pin_wake;
  logic tag_hit;
  logic last_burst;
  logic enter_cmd;
  logic [CNT_A_W-1:0] gap_ticks;
  logic [7:0] enter_ctrl;
  logic [7:0] limit_byte;

  // ***************************************************************
  // Pin synchronisers and counters
  // ***************************************************************
  wse_sync #(.W(4), .INIT(4'h3)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_rf_swing, i_slow_osc, i_ser_sel_n, i_wake_req_n}),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  wse_sync #(.W(6), .INIT(6'h00)) u_dac_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_dac_level),
    .o_level(dac_sync),
    .o_rise(),
    .o_fall()
  );

  assign req_fall = pin_fall[0];
  assign sel_fall = pin_fall[1];
  assign slow_tick = pin_rise[2];
  assign swing_tick = pin_rise[3];

  // Slow-tick waits: gap, oscillator and DAC settling
  wse_cnt #(.W(CNT_A_W)) u_cnt_slow (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(a_load),
    .i_value(a_value),
    .i_step(slow_tick),
    .o_count(a_count),
    .o_done(a_done)
  );

  // Fast waits: start-up delay on the clock, burst length on swings
  wse_cnt #(.W(CNT_B_W)) u_cnt_fast (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_load(b_load),
    .i_value(b_value),
    .i_step((r_reg.st == ST_START) | swing_tick),
    .o_count(b_count),
    .o_done(b_done)
  );

  // ***************************************************************
  // Frame decode
  // ***************************************************************
  function automatic logic [7:0] frame_byte(input logic [3:0][31:0] f, input int pos);
    frame_byte = f[(pos - 1) / 4][8 * ((pos - 1) % 4) +: 8];
  endfunction : frame_byte

  function automatic logic [31:0] rd_mux(input wse_seq_s s, input logic [7:0] a);
    case (a)
      REG_STATUS: rd_mux = {s.ready, 6'h00, s.st, 2'h0, s.dac_raw, s.reason};
      REG_FRAME0: rd_mux = s.frame[0];
      REG_FRAME1: rd_mux = s.frame[1];
      REG_FRAME2: rd_mux = s.frame[2];
      REG_FRAME3: rd_mux = s.frame[3];
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction : rd_mux

  assign wsrc = frame_byte(r_reg.frame, POS_WAKE_SRC);
  assign gap_ticks = {{1'b0, frame_byte(r_reg.frame, POS_COEFF)} + COEFF_OFFSET,
                      BASE_TICKS_LSB};
  assign pin_reason = wsrc & ((WS_REQ & {8{req_fall}}) | (WS_SEL & {8{sel_fall}}));
  assign pin_wake = (pin_reason != 8'h00);
  assign tag_hit = (r_reg.meas > frame_byte(r_reg.frame, POS_THR_HI)) ||
                   (r_reg.meas < frame_byte(r_reg.frame, POS_THR_LO));
  assign enter_ctrl = frame_byte(r_reg.frame, POS_ENTER_L);
  assign limit_byte = frame_byte(r_reg.frame, POS_LIMIT);
  assign last_burst = wsrc[WS_TIMEOUT_BIT] &&
                      (r_reg.bursts == {1'b0, limit_byte[LIMIT_W-1:0]});
  assign enter_cmd = r_reg.ph_wr && (r_reg.ph_addr == REG_CTRL) &&
                     i_hwdata[CTRL_ENTER_BIT];

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    r_next = r_reg;
    a_load = 1'b0;
    a_value = gap_ticks;
    b_load = 1'b0;
    b_value = CNT_B_W'(STARTUP_CNT);
    // Bus: zero wait states, read data registered at the address phase
    r_next.ph_wr = 1'b0;
    r_next.hreadyout = 1'b1;
    if (i_hsel && i_htrans[1] && i_hready) begin
      r_next.ph_wr = i_hwrite;
      r_next.ph_addr = i_haddr[7:0];
      if (!i_hwrite) begin
        r_next.hrdata = rd_mux(r_reg, i_haddr[7:0]);
      end
    end
    if (r_reg.ph_wr) begin
      case (r_reg.ph_addr)
        REG_FRAME0: r_next.frame[0] = i_hwdata;
        REG_FRAME1: r_next.frame[1] = i_hwdata;
        REG_FRAME2: r_next.frame[2] = i_hwdata;
        REG_FRAME3: r_next.frame[3] = i_hwdata;
        default: r_next.frame = r_reg.frame;
      endcase
    end
    case (r_reg.st)
      ST_PWRUP: begin
        if (req_fall) begin
          r_next.st = ST_START;
          b_load = 1'b1;
        end
      end
      ST_START: begin
        if (b_done) begin
          r_next.st = ST_READY;
        end
      end
      ST_READY: begin
        if (enter_cmd) begin
          r_next.bursts = '0;
          if (enter_ctrl[ENTER_HIBER_BIT]) begin
            r_next.st = ST_HIBER;
          end else begin
            r_next.st = ST_GAP;
            a_load = 1'b1;
          end
        end
      end
      ST_HIBER: begin
        if (req_fall) begin
          r_next.st = ST_START;
          r_next.reason = REASON_RST;
          b_load = 1'b1;
        end
      end
      ST_GAP: begin
        if (pin_wake) begin
          r_next.st = ST_READY;
          r_next.reason = pin_reason;
        end else if (a_done) begin
          if (wsrc[WS_TAG_BIT]) begin
            r_next.st = ST_OSC;
            a_load = 1'b1;
            a_value = CNT_A_W'(frame_byte(r_reg.frame, POS_OSC));
          end else if (last_burst) begin
            r_next.st = ST_READY;
            r_next.reason = WS_TIMEOUT;
          end else begin
            r_next.bursts = r_reg.bursts + 1'b1;
            a_load = 1'b1;
          end
        end
      end
      ST_OSC: begin
        if (pin_wake) begin
          r_next.st = ST_READY;
          r_next.reason = pin_reason;
        end else if (a_done) begin
          r_next.st = ST_DAC;
          a_load = 1'b1;
          a_value = CNT_A_W'(frame_byte(r_reg.frame, POS_DAC));
        end
      end
      ST_DAC: begin
        if (pin_wake) begin
          r_next.st = ST_READY;
          r_next.reason = pin_reason;
        end else if (a_done) begin
          r_next.st = ST_BURST;
          b_load = 1'b1;
          b_value = CNT_B_W'(frame_byte(r_reg.frame, POS_SWING));
        end
      end
      ST_BURST: begin
        if (pin_wake) begin
          r_next.st = ST_READY;
          r_next.reason = pin_reason;
        end else if (b_done) begin
          r_next.st = ST_CMP;
          r_next.dac_raw = dac_sync;
          r_next.meas = {dac_sync, 2'b00};
        end
      end
      ST_CMP: begin
        if (pin_wake) begin
          r_next.st = ST_READY;
          r_next.reason = pin_reason;
        end else if (tag_hit) begin
          r_next.st = ST_READY;
          r_next.reason = WS_TAG;
        end else if (last_burst) begin
          r_next.st = ST_READY;
          r_next.reason = WS_TIMEOUT;
        end else begin
          r_next.st = ST_GAP;
          r_next.bursts = r_reg.bursts + 1'b1;
          a_load = 1'b1;
        end
      end
      default: begin
        r_next.st = ST_PWRUP;
      end
    endcase
    r_next.slow_en = (r_next.st inside {ST_GAP, ST_OSC, ST_DAC, ST_BURST, ST_CMP}) &&
                     (wsrc[WS_TIMEOUT_BIT] || wsrc[WS_TAG_BIT]);
    r_next.slow_sel = wsrc[WS_FSEL_LSB +: 2];
    r_next.fast_en = r_next.st inside {ST_OSC, ST_DAC, ST_BURST};
    r_next.dac_en = r_next.st inside {ST_DAC, ST_BURST};
    r_next.rf_en = (r_next.st == ST_BURST);
    r_next.ready = (r_next.st == ST_READY);
    r_next.hiber = (r_next.st == ST_HIBER);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
      r_reg.st <= ST_PWRUP;
      r_reg.frame <= {FRAME_RST, FRAME_RST, FRAME_RST, FRAME_RST};
      r_reg.reason <= REASON_RST;
      r_reg.hreadyout <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_hrdata = r_reg.hrdata;
  assign o_hreadyout = r_reg.hreadyout;
  assign o_hresp = 1'b0;
  assign o_slow_osc_en = r_reg.slow_en;
  assign o_slow_osc_sel = r_reg.slow_sel;
  assign o_fast_osc_en = r_reg.fast_en;
  assign o_dac_en = r_reg.dac_en;
  assign o_rf_burst_en = r_reg.rf_en;
  assign o_ready = r_reg.ready;
  assign o_hibernate = r_reg.hiber;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_osc_to_dac;
    (r_reg.st == ST_OSC) ##1 (r_reg.st == ST_DAC);
  endsequence

  property p_pwrup_wake;
    (r_reg.st == ST_PWRUP) && req_fall |=> (r_reg.st == ST_START);
  endproperty
  a_pwrup_wake: assert property (p_pwrup_wake) else $error("power-up not left on wake");

  property p_hiber_hold;
    (r_reg.st == ST_HIBER) && !req_fall |=> (r_reg.st == ST_HIBER) && o_hibernate;
  endproperty
  a_hiber_hold: assert property (p_hiber_hold) else $error("hibernate left wrongly");

  property p_slow_on;
    (r_reg.st == ST_GAP) && wsrc[WS_TIMEOUT_BIT] |-> o_slow_osc_en;
  endproperty
  a_slow_on: assert property (p_slow_on) else $error("slow osc off with timeout");

  property p_burst_tag;
    o_rf_burst_en |-> wsrc[WS_TAG_BIT] && o_fast_osc_en && o_dac_en;
  endproperty
  a_burst_tag: assert property (p_burst_tag) else $error("burst without tag enable");

  property p_gap_load;
    (r_reg.st != ST_GAP) ##1 (r_reg.st == ST_GAP) |-> (a_count == gap_ticks);
  endproperty
  a_gap_load: assert property (p_gap_load) else $error("gap length wrong");

  property p_settle_order;
    (r_reg.st == ST_OSC) && a_done && !pin_wake |-> s_osc_to_dac;
  endproperty
  a_settle_order: assert property (p_settle_order) else $error("DAC settle skipped");

  property p_swing_len;
    $rose(r_reg.st == ST_BURST) |-> (b_count == CNT_B_W'(frame_byte(r_reg.frame, POS_SWING)));
  endproperty
  a_swing_len: assert property (p_swing_len) else $error("burst length wrong");

  property p_tag_wake;
    (r_reg.st == ST_CMP) && !pin_wake && tag_hit |=> o_ready && (r_reg.reason == WS_TAG);
  endproperty
  a_tag_wake: assert property (p_tag_wake) else $error("tag wake missed");

  property p_timeout_wake;
    (r_reg.st == ST_CMP) && !pin_wake && !tag_hit && last_burst
      |=> o_ready && (r_reg.reason == WS_TIMEOUT);
  endproperty
  a_timeout_wake: assert property (p_timeout_wake) else $error("timeout missed");

  property p_endless;
    (r_reg.st == ST_CMP) && !pin_wake && !tag_hit && !wsrc[WS_TIMEOUT_BIT]
      |=> (r_reg.st == ST_GAP);
  endproperty
  a_endless: assert property (p_endless) else $error("burst loop ended");

  property p_pin_reason;
    (r_reg.st == ST_GAP) && req_fall && wsrc[3] |=> o_ready && r_reg.reason[3];
  endproperty
  a_pin_reason: assert property (p_pin_reason) else $error("pin wake not recorded");

endmodule : wse_seq

// File: hdl/wse_pkg.sv
/*
 * Package of the wake-event sequencer: register map, idle frame byte
 * positions, wake source masks, state codes and timing constants.
 * Assumes a 250 MHz system clock and 32-bit AHB-Lite register access.
 */
package wse_pkg;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FRAME0 = 8'h10;
  localparam logic [7:0] REG_FRAME1 = 8'h14;
  localparam logic [7:0] REG_FRAME2 = 8'h18;
  localparam logic [7:0] REG_FRAME3 = 8'h1C;
  localparam logic [31:0] FRAME_RST = 32'h0000_0000;
  localparam int CTRL_ENTER_BIT = 0;

  // ***************************************************************
  // Idle frame byte positions (position 1 is the command code)
  // ***************************************************************
  localparam int POS_WAKE_SRC = 3;
  localparam int POS_ENTER_L = 4;
  localparam int POS_COEFF = 10;
  localparam int POS_OSC = 11;
  localparam int POS_DAC = 12;
  localparam int POS_THR_LO = 13;
  localparam int POS_THR_HI = 14;
  localparam int POS_SWING = 15;
  localparam int POS_LIMIT = 16;
  localparam int ENTER_HIBER_BIT = 2;

  // ***************************************************************
  // Wake source byte
  // ***************************************************************
  localparam logic [7:0] WS_TIMEOUT = 8'h01;
  localparam logic [7:0] WS_TAG = 8'h02;
  localparam logic [7:0] WS_REQ = 8'h08;
  localparam logic [7:0] WS_SEL = 8'h10;
  localparam int WS_TIMEOUT_BIT = 0;
  localparam int WS_TAG_BIT = 1;
  localparam int WS_FSEL_LSB = 6;
  localparam logic [7:0] REASON_RST = 8'h00;
  localparam int LIMIT_W = 5;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_FREQ_KHZ = 250000;
  localparam int STARTUP_DELAY_MS = 6;
  localparam int STARTUP_CYCLES = STARTUP_DELAY_MS * CLK_FREQ_KHZ;
  localparam logic [7:0] BASE_TICKS_LSB = 8'h00;
  localparam logic [8:0] COEFF_OFFSET = 9'h002;
  localparam int CNT_A_W = 17;
  localparam int CNT_B_W = 21;

  // ***************************************************************
  // Sequencer states
  // ***************************************************************
  typedef enum logic [8:0] {
    ST_PWRUP = 9'h001,
    ST_START = 9'h002,
    ST_READY = 9'h004,
    ST_HIBER = 9'h008,
    ST_GAP = 9'h010,
    ST_OSC = 9'h020,
    ST_DAC = 9'h040,
    ST_BURST = 9'h080,
    ST_CMP = 9'h100
  } wse_state_e;

endpackage : wse_pkg

// File: hdl/wse_sync.sv
/*
 * Two-flop synchroniser with a third stage for edge detection.
 * Assumes inputs come from pins outside the i_clk domain.
 */
`timescale 1ns/100ps
module wse_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise,
  output logic [W-1:0] o_fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } wse_sync_s;

  wse_sync_s r_reg;
  wse_sync_s r_next;

  always_comb begin
    r_next.s1 = i_async;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_reg <= {INIT, INIT, INIT};
    end else begin
      r_reg <= r_next;
    end
  end

  // Only the second and third stages feed logic
  assign o_level = r_reg.s2;
  assign o_rise = r_reg.s2 & ~r_reg.s3;
  assign o_fall = ~r_reg.s2 & r_reg.s3;

endmodule : wse_sync

// File: hdl/wse_cnt.sv
/*
 * Loadable down counter that steps on an enable and flags zero.
 * Assumes load and step come from logic on the same clock.
 */
`timescale 1ns/100ps
module wse_cnt #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  input wire logic i_step,
  output logic [W-1:0] o_count,
  output logic o_done
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } wse_cnt_s;

  wse_cnt_s r_reg;
  wse_cnt_s r_next;

  always_comb begin
    r_next = r_reg;
    if (i_load) begin
      r_next.cnt = i_value;
    end else if (i_step && (r_reg.cnt != '0)) begin
      r_next.cnt = r_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_count = r_reg.cnt;
  assign o_done = (r_reg.cnt == '0);

endmodule : wse_cnt

// File: sim/wse_far_model.sv
/* Far-side model: slow oscillator and carrier swings.
 * Assumes enables come from wse_seq on the same i_clk. */
`timescale 1ns/100ps
module wse_far_model (
  input wire logic i_clk,
  input wire logic i_slow_en,
  input wire logic i_burst_en,
  output logic o_slow_osc,
  output logic o_rf_swing,
  output int o_swings
);
  logic [2:0] div = 3'h0;
  logic b_d = 1'b0;
  logic slow_r = 1'b0;
  logic swing_r = 1'b0;
  int swings_r = 0;
  assign o_slow_osc = slow_r;
  assign o_rf_swing = swing_r;
  assign o_swings = swings_r;
  // Both oscillators stand low while disabled
  always @(posedge i_clk) begin
    div <= div + 3'h1;
    b_d <= i_burst_en;
    slow_r <= i_slow_en && div[2];
    swing_r <= i_burst_en && div[1];
    if (i_burst_en && !b_d) begin
      swings_r <= 0;
    end else if (i_burst_en && div[1:0] == 2'h1) begin
      swings_r <= swings_r + 1;
    end
  end
endmodule : wse_far_model

// File: sim/test_wse_seq.sv
/* Self-checking bench of wse_seq acting as host over AHB-Lite and pins.
 * Assumes wse_far_model supplies slow oscillator and carrier swings. */
`timescale 1ns/100ps
module test_wse_seq;
  import wse_pkg::*;
  localparam int SU = 20;
  logic i_clk, i_rst_n, hsel, hwrite, req_n, sel_n, dph_rd, hrdy, hresp;
  logic slow_en, fast_en, dac_en, burst_en, rdy, hib, slow, swing;
  logic slow_d = 1'b0, burst_d = 1'b0, fast_d = 1'b0;
  logic [1:0] htrans, osc_sel;
  logic [2:0] hsize;
  logic [5:0] dac;
  logic [31:0] haddr, hwdata, hrdata, rs, ex;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0, total_checks = 0, swings, ticks = 0, bursts = 0, oticks = 0, t0, b0;

  wse_seq #(.STARTUP_CNT(SU)) i_wse_seq (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .i_wake_req_n(req_n), .i_ser_sel_n(sel_n), .i_slow_osc(slow),
    .i_rf_swing(swing), .i_dac_level(dac), .o_slow_osc_en(slow_en),
    .o_slow_osc_sel(osc_sel), .o_fast_osc_en(fast_en), .o_dac_en(dac_en),
    .o_rf_burst_en(burst_en), .o_ready(rdy), .o_hibernate(hib));
  wse_far_model i_wse_far_model (.i_clk(i_clk), .i_slow_en(slow_en),
    .i_burst_en(burst_en), .o_slow_osc(slow), .o_rf_swing(swing), .o_swings(swings));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    if (!w) begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : ~d;
    dph_rd <= !w;
    @(posedge i_clk);
    while (hrdy !== 1'b1) @(posedge i_clk);
    dph_rd <= 1'b0;
  endtask : bus

  task automatic enter(input logic [7:0] ws, en, co, os, ds, lo, hi, sw, li);
    bus(REG_FRAME0, 1'b1, {en, ws, 8'h0E, 8'h07}, 32'h0);
    bus(REG_FRAME2, 1'b1, {ds, os, co, 8'h00}, 32'h0);
    bus(REG_FRAME3, 1'b1, {li, sw, hi, lo}, 32'h0);
    t0 = ticks;
    b0 = bursts;
    bus(REG_CTRL, 1'b1, 32'h1, 32'h0);
  endtask : enter

  task automatic wait_rdy(input int n);
    int k;
    k = 0;
    repeat (2) @(posedge i_clk);
    while (rdy !== 1'b1 && k < n) begin
      @(posedge i_clk);
      k++;
    end
    check(rdy, 1'b1);
  endtask : wait_rdy

  task automatic pulse(input logic r);
    @(posedge i_clk);
    if (r) req_n <= 1'b0;
    else sel_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    req_n <= 1'b1;
    sel_n <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask : pulse

  // Read data is taken at the edge that ends the data phase
  always @(posedge i_clk) begin
    if (dph_rd && hrdy === 1'b1 && exp_q.size() > 0) begin
      check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  always @(posedge i_clk) begin
    slow_d <= slow;
    burst_d <= burst_en;
    fast_d <= fast_en;
    if (slow && !slow_d) ticks <= ticks + 1;
    if (burst_en && !burst_d) bursts <= bursts + 1;
    if (fast_en && !fast_d) oticks <= 0;
    else if (fast_en && !dac_en && slow && !slow_d) oticks <= oticks + 1;
  end

  initial begin
    #(60000 * 4);
    fails++;
    finish_test();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    {hsel, hwrite, dph_rd, i_rst_n} = 4'h0;
    {htrans, haddr, hwdata, dac} = '0;
    {req_n, sel_n} = 2'h3;
    hsize = 3'h2;
    rs = 32'd55144;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    bus(REG_FRAME1, 1'b0, FRAME_RST, 32'hFFFFFFFF);
    bus(8'h40, 1'b1, 32'hFFFFFFFF, 32'h0);
    bus(8'h40, 1'b0, 32'h0, 32'hFFFFFFFF);
    bus(REG_STATUS, 1'b0, 32'h00010000, 32'h81FF00FF);
    pulse(1'b0);
    check(rdy, 1'b0);
    pulse(1'b1);
    check(rdy, 1'b0);
    wait_rdy(SU + 20);
    bus(REG_STATUS, 1'b0, 32'h80040000, 32'h81FF0000);
    enter(8'hC1, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    repeat (3) @(posedge i_clk);
    check(slow_en, 1'b1);
    check(osc_sel, 2'h3);
    wait_rdy(12000);
    check((ticks - t0) inside {[1022:1026]}, 1'b1);
    check(bursts - b0, 32'h0);
    bus(REG_STATUS, 1'b0, 32'h01, 32'hFF);
    for (int i = 0; i < 3; i++) begin
      rs = xs(rs);
      dac <= rs[5:0];
      enter(8'h0B, 8'h00, 8'h00, 8'h03, 8'h02, 8'h78, 8'h88, 8'h05, 8'h01);
      wait_rdy(12000);
      ex = ({rs[5:0], 2'h0} > 8'h88 || {rs[5:0], 2'h0} < 8'h78) ? 32'h2 : 32'h1;
      check(swings inside {[5:6]}, 1'b1);
      check(oticks inside {[2:4]}, 1'b1);
      check(bursts - b0, (ex == 32'h2) ? 32'h1 : 32'h2);
      bus(REG_STATUS, 1'b0, {18'h0, rs[5:0], ex[7:0]}, 32'h3FFF);
    end
    for (int p = 0; p < 2; p++) begin
      enter(p ? 8'h12 : 8'h0A, 8'h00, 8'h00, 8'h03, 8'h02, 8'h00, 8'hFE, 8'h05, 8'h01);
      repeat (50) @(posedge i_clk);
      pulse(p == 0);
      wait_rdy(100);
      bus(REG_STATUS, 1'b0, p ? 32'h10 : 32'h08, 32'hFF);
    end
    enter(8'h19, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
    pulse(1'b0);
    repeat (20) @(posedge i_clk);
    check(hib, 1'b1);
    pulse(1'b1);
    wait_rdy(SU + 40);
    bus(REG_STATUS, 1'b0, 32'h0, 32'hFF);
    check(hresp, 1'b0);
    finish_test();
  end
endmodule : test_wse_seq
